// ===== design/fbp_pkg.sv
// Shared constants and types for the parallel flash bus port.
// Assumes both ends run on one clock and meet through fbp_bus_if.
`default_nettype none
package fbp_pkg;
    // Pin widths and array index width
    localparam int ADDR_MSB = 25;
    localparam int DATA_W   = 16;
    localparam int ARR_IW   = 9;

    // Command codes written on the data lines
    localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;
    localparam logic [15:0] CMD_READ_STATUS   = 16'h0070;
    localparam logic [15:0] CMD_READ_IDENT    = 16'h0090;
    localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0050;
    localparam logic [15:0] CMD_PROGRAM       = 16'h0040;
    localparam logic [15:0] CMD_CFG_SETUP     = 16'h0060;
    localparam logic [15:0] CMD_CFG_CONFIRM   = 16'h0003;

    // Read configuration layout and reset value
    localparam logic [15:0] CFG_RESET         = 16'hBFCF;
    localparam int          CFG_ASYNC_BIT     = 15;
    localparam int          CFG_POL_BIT       = 10;
    localparam int          CFG_LAT_LSB       = 11;
    localparam int          CFG_LAT_W         = 3;

    // Status and identifier words
    localparam logic [15:0] STATUS_RESET      = 16'h0080;
    localparam logic [15:0] STATUS_ERR        = 16'h0010;
    localparam logic [15:0] ERASED_WORD       = 16'hFFFF;
    localparam logic [7:0]  IDENT_CFG_OFS     = 8'h05;
    // Arbitrary identifier value
    localparam logic [15:0] IDENT_VALUE       = 16'h0A5A;

    // Host timing in clock cycles
    localparam logic [3:0]  ASYNC_READ_CYC    = 4'h4;
    localparam logic [3:0]  WRITE_LOW_CYC     = 4'h3;

    typedef enum logic [2:0] {
        MODE_ARRAY  = 3'b001,
        MODE_STATUS = 3'b010,
        MODE_IDENT  = 3'b100
    } fbp_mode_type;

    typedef enum logic [6:0] {
        H_IDLE  = 7'b0000001,
        H_WLOW  = 7'b0000010,
        H_WHIGH = 7'b0000100,
        H_ARD   = 7'b0001000,
        H_SADR  = 7'b0010000,
        H_SCLK  = 7'b0100000,
        H_DONE  = 7'b1000000
    } fbp_hstate_type;
endpackage
`default_nettype wire

// ===== design/fbp_bus_if.sv
// Pin bundle between the flash device end and the host end.
// Resolves the shared data line from each side's enable and the ready line from the device's.
`timescale 1ns/1ps
`default_nettype none
interface fbp_bus_if;
    logic [25:1] addr;
    logic        die_sel_n;
    logic        out_en_n;
    logic        write_en_n;
    logic        address_latch_strobe_n;
    logic        bus_clk;
    logic        flash_rst_n;
    logic [15:0] host_dq;
    logic        host_dq_oe;
    logic [15:0] dev_dq;
    logic        dev_dq_oe;
    logic        ready_val;
    logic        ready_oe;
    logic [15:0] dq;
    logic        ready_flag;

    // Undriven lines read as pulled high
    assign dq = host_dq_oe ? host_dq : (dev_dq_oe ? dev_dq : 16'hFFFF);
    assign ready_flag = ready_oe ? ready_val : 1'b1;

    modport dev (
        input  addr, die_sel_n, out_en_n, write_en_n,
        input  address_latch_strobe_n, bus_clk, flash_rst_n, dq,
        output dev_dq, dev_dq_oe, ready_val, ready_oe
    );
    modport host (
        output addr, die_sel_n, out_en_n, write_en_n,
        output address_latch_strobe_n, bus_clk, flash_rst_n,
        output host_dq, host_dq_oe,
        input  dq, ready_flag
    );
endinterface
`default_nettype wire

// ===== design/fbp_array.sv
// Word storage for both stacked dies, erased until first written.
// Assumes the caller gates writes and forms the word index.
`timescale 1ns/1ps
`default_nettype none
module fbp_array (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Write port
    input  wire logic                      wr_en,
    input  wire logic [fbp_pkg::ARR_IW-1:0] wr_idx,
    input  wire logic [15:0]               wr_data,
    // Read port
    input  wire logic [fbp_pkg::ARR_IW-1:0] rd_idx,
    output logic      [15:0]               rd_data
);
    localparam int DEPTH = 1 << fbp_pkg::ARR_IW;

    logic [15:0]      mem_q [DEPTH];
    logic [DEPTH-1:0] valid_q;

    // Unwritten words read as erased
    assign rd_data = valid_q[rd_idx] ? mem_q[rd_idx] : fbp_pkg::ERASED_WORD;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            valid_q <= '0;
        end else if (wr_en) begin
            valid_q[wr_idx] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== design/fbp_device.sv
// Flash device end of the parallel bus: address capture, data drive,
// ready flag, write decode and configuration.
// Assumes the host end runs on the same clock, so pins need no sync.
`timescale 1ns/1ps
`default_nettype none
module fbp_device (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Flash pins
    fbp_bus_if.dev    bus
);
    // Die index plus low word bits; address bit 1 is the word LSB
    function automatic logic [fbp_pkg::ARR_IW-1:0] arr_index(
        input logic [25:1] a
    );
        arr_index = {a[fbp_pkg::ADDR_MSB], a[8:1]};
    endfunction

    logic                        alsn_q;
    logic                        bclk_q;
    logic                        we_q;
    logic [25:1]                 held_addr_q;
    logic [25:1]                 held_addr_d;
    logic [25:1]                 sync_addr_q;
    logic [25:1]                 sync_addr_d;
    logic [fbp_pkg::CFG_LAT_W-1:0] lat_q;
    logic [fbp_pkg::CFG_LAT_W-1:0] lat_d;
    logic                        burst_q;
    logic                        burst_d;
    logic                        captured_q;
    logic                        captured_d;
    fbp_pkg::fbp_mode_type       mode_q;
    fbp_pkg::fbp_mode_type       mode_d;
    logic                        prog_pend_q;
    logic                        prog_pend_d;
    logic                        cfg_pend_q;
    logic                        cfg_pend_d;
    logic [15:0]                 cfg_q;
    logic [15:0]                 cfg_d;
    logic [15:0]                 status_q;
    logic [15:0]                 status_d;
    logic [15:0]                 dq_q;
    logic                        dq_oe_q;
    logic                        ready_q;
    logic                        ready_oe_q;

    // Edge and mode decode
    wire rst_all     = !reset_n || !bus.flash_rst_n;
    wire selected    = !bus.die_sel_n;
    wire alsn_rise   = bus.address_latch_strobe_n & ~alsn_q;
    wire alsn_fall   = ~bus.address_latch_strobe_n & alsn_q;
    wire bclk_rise   = bus.bus_clk & ~bclk_q;
    wire sync_mode   = ~cfg_q[fbp_pkg::CFG_ASYNC_BIT];
    wire ready_pol   = cfg_q[fbp_pkg::CFG_POL_BIT];
    wire [fbp_pkg::CFG_LAT_W-1:0] cfg_lat =
        cfg_q[fbp_pkg::CFG_LAT_LSB +: fbp_pkg::CFG_LAT_W];

    wire we_rise = bus.write_en_n & ~we_q & selected & ~rst_all;

    wire [25:1] async_addr = bus.address_latch_strobe_n ? held_addr_q
                                                        : bus.addr;
    assign held_addr_d = bus.address_latch_strobe_n ? held_addr_q : bus.addr;

    wire cap_strobe = sync_mode & selected & alsn_rise & ~captured_q;
    wire cap_clk    = sync_mode & selected & bclk_rise
                      & ~bus.address_latch_strobe_n & ~captured_q;
    wire capture    = cap_strobe | cap_clk;
    wire [25:1] cap_addr = cap_strobe ? held_addr_q : bus.addr;
    wire lat_done   = lat_q == '0;
    wire advance    = burst_q & bclk_rise & lat_done & ~capture;

    assign sync_addr_d = capture ? cap_addr
                       : advance ? 25'(sync_addr_q + 25'h1) : sync_addr_q;
    assign lat_d = capture ? cfg_lat
                 : (bclk_rise & ~lat_done) ? lat_q - 3'h1 : lat_q;
    assign burst_d = capture ? 1'b1 : (selected ? burst_q : 1'b0);
    assign captured_d = capture ? 1'b1
                      : (!selected || alsn_fall) ? 1'b0 : captured_q;

    wire [25:1] rd_addr = sync_mode ? sync_addr_q : async_addr;
    wire [15:0] arr_rdata;

    wire [15:0] ident_word = (rd_addr[8:1] == fbp_pkg::IDENT_CFG_OFS)
                             ? cfg_q : fbp_pkg::IDENT_VALUE;
    wire [15:0] read_word =
        (mode_q == fbp_pkg::MODE_STATUS) ? status_q
      : (mode_q == fbp_pkg::MODE_IDENT)  ? ident_word : arr_rdata;

    wire drive = selected & ~bus.out_en_n & bus.write_en_n & ~rst_all;

    wire wait_on   = sync_mode & (capture | (burst_q & ~lat_done));
    wire ready_nxt = wait_on ? ready_pol : ~ready_pol;

    wire arr_we = we_rise & prog_pend_q;

    fbp_array u_array (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (arr_we),
        .wr_idx  (arr_index(bus.addr)),
        .wr_data (bus.dq),
        .rd_idx  (arr_index(rd_addr)),
        .rd_data (arr_rdata)
    );

    always_comb begin
        mode_d      = mode_q;
        prog_pend_d = prog_pend_q;
        cfg_pend_d  = cfg_pend_q;
        cfg_d       = cfg_q;
        status_d    = status_q;
        if (we_rise) begin
            if (prog_pend_q) begin
                prog_pend_d = 1'b0;
                mode_d      = fbp_pkg::MODE_STATUS;
            end else if (cfg_pend_q) begin
                cfg_pend_d = 1'b0;
                if (bus.dq == fbp_pkg::CMD_CFG_CONFIRM) begin
                    cfg_d = bus.addr[16:1];
                end else begin
                    status_d = status_q | fbp_pkg::STATUS_ERR;
                end
            end else begin
                case (bus.dq)
                    fbp_pkg::CMD_READ_ARRAY: begin
                        mode_d = fbp_pkg::MODE_ARRAY;
                    end
                    fbp_pkg::CMD_READ_STATUS: begin
                        mode_d = fbp_pkg::MODE_STATUS;
                    end
                    fbp_pkg::CMD_READ_IDENT: begin
                        mode_d = fbp_pkg::MODE_IDENT;
                    end
                    fbp_pkg::CMD_CLEAR_STATUS: begin
                        status_d = fbp_pkg::STATUS_RESET;
                    end
                    fbp_pkg::CMD_PROGRAM: begin
                        prog_pend_d = 1'b1;
                        mode_d      = fbp_pkg::MODE_STATUS;
                    end
                    fbp_pkg::CMD_CFG_SETUP: begin
                        cfg_pend_d = 1'b1;
                    end
                    default: begin
                        status_d = status_q | fbp_pkg::STATUS_ERR;
                    end
                endcase
            end
        end
    end

    // Pin history for edge detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alsn_q      <= 1'b0;
            bclk_q      <= 1'b0;
            we_q        <= 1'b1;
            held_addr_q <= '0;
        end else begin
            alsn_q      <= bus.address_latch_strobe_n;
            bclk_q      <= bus.bus_clk;
            we_q        <= bus.write_en_n;
            held_addr_q <= held_addr_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            mode_q      <= fbp_pkg::MODE_ARRAY;
            prog_pend_q <= 1'b0;
            cfg_pend_q  <= 1'b0;
            cfg_q       <= fbp_pkg::CFG_RESET;
            status_q    <= fbp_pkg::STATUS_RESET;
            sync_addr_q <= '0;
            lat_q       <= '0;
            burst_q     <= 1'b0;
            captured_q  <= 1'b0;
        end else begin
            mode_q      <= mode_d;
            prog_pend_q <= prog_pend_d;
            cfg_pend_q  <= cfg_pend_d;
            cfg_q       <= cfg_d;
            status_q    <= status_d;
            sync_addr_q <= sync_addr_d;
            lat_q       <= lat_d;
            burst_q     <= burst_d;
            captured_q  <= captured_d;
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dq_q       <= '0;
            dq_oe_q    <= 1'b0;
            ready_q    <= 1'b0;
            ready_oe_q <= 1'b0;
        end else begin
            dq_q       <= read_word;
            dq_oe_q    <= drive;
            ready_q    <= ready_nxt;
            ready_oe_q <= drive;
        end
    end

    assign bus.dev_dq    = dq_q;
    assign bus.dev_dq_oe = dq_oe_q;
    assign bus.ready_val = ready_q;
    assign bus.ready_oe  = ready_oe_q;
endmodule
`default_nettype wire

// ===== design/fbp_host.sv
// Host end of the flash bus: runs one write, async read or sync read
// per request. Assumes the device end shares the clock.
`timescale 1ns/1ps
`default_nettype none
module fbp_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Request
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic        cmd_sync,
    input  wire logic [25:1] cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        ready_pol,
    output logic             cmd_ready,
    // Answer
    output logic             rsp_valid,
    output logic      [15:0] rsp_data,
    // Flash pins
    fbp_bus_if.host          bus
);
    fbp_pkg::fbp_hstate_type state_q;
    logic [3:0]              cnt_q;
    logic [25:1]             addr_q;
    logic [15:0]             dq_q;
    logic                    dq_oe_q;
    logic                    die_sel_n_q;
    logic                    oe_n_q;
    logic                    we_n_q;
    logic                    alsn_q;
    logic                    bclk_q;
    logic                    rst_n_q;

    wire cnt_zero  = cnt_q == 4'h0;
    wire ready_ok  = bus.ready_flag == ~ready_pol;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q     <= fbp_pkg::H_IDLE;
            cnt_q       <= 4'h0;
            addr_q      <= '0;
            dq_q        <= '0;
            dq_oe_q     <= 1'b0;
            die_sel_n_q <= 1'b1;
            oe_n_q      <= 1'b1;
            we_n_q      <= 1'b1;
            alsn_q      <= 1'b0;
            bclk_q      <= 1'b0;
            rst_n_q     <= 1'b0;
            cmd_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_data    <= '0;
        end else begin
            rst_n_q   <= 1'b1;
            rsp_valid <= 1'b0;
            cnt_q     <= cnt_zero ? 4'h0 : cnt_q - 4'h1;
            case (state_q)
                fbp_pkg::H_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready   <= 1'b0;
                        addr_q      <= cmd_addr;
                        die_sel_n_q <= 1'b0;
                        if (cmd_write) begin
                            we_n_q  <= 1'b0;
                            dq_q    <= cmd_wdata;
                            dq_oe_q <= 1'b1;
                            cnt_q   <= fbp_pkg::WRITE_LOW_CYC - 4'h1;
                            state_q <= fbp_pkg::H_WLOW;
                        end else if (cmd_sync) begin
                            oe_n_q  <= 1'b0;
                            state_q <= fbp_pkg::H_SADR;
                        end else begin
                            oe_n_q  <= 1'b0;
                            cnt_q   <= fbp_pkg::ASYNC_READ_CYC - 4'h1;
                            state_q <= fbp_pkg::H_ARD;
                        end
                    end
                end
                fbp_pkg::H_WLOW: begin
                    if (cnt_zero) begin
                        we_n_q  <= 1'b1;
                        state_q <= fbp_pkg::H_WHIGH;
                    end
                end
                fbp_pkg::H_WHIGH: begin
                    die_sel_n_q <= 1'b1;
                    dq_oe_q     <= 1'b0;
                    rsp_valid   <= 1'b1;
                    rsp_data    <= '0;
                    state_q     <= fbp_pkg::H_DONE;
                end
                fbp_pkg::H_ARD: begin
                    if (cnt_zero) begin
                        rsp_valid   <= 1'b1;
                        rsp_data    <= bus.dq;
                        oe_n_q      <= 1'b1;
                        die_sel_n_q <= 1'b1;
                        state_q     <= fbp_pkg::H_DONE;
                    end
                end
                fbp_pkg::H_SADR: begin
                    bclk_q  <= 1'b1;
                    state_q <= fbp_pkg::H_SCLK;
                end
                fbp_pkg::H_SCLK: begin
                    bclk_q <= ~bclk_q;
                    if (bclk_q) begin
                        alsn_q <= 1'b1;
                    end
                    if (alsn_q && ready_ok) begin
                        rsp_valid   <= 1'b1;
                        rsp_data    <= bus.dq;
                        bclk_q      <= 1'b0;
                        alsn_q      <= 1'b0;
                        oe_n_q      <= 1'b1;
                        die_sel_n_q <= 1'b1;
                        state_q     <= fbp_pkg::H_DONE;
                    end
                end
                fbp_pkg::H_DONE: begin
                    state_q <= fbp_pkg::H_IDLE;
                end
                default: begin
                    state_q <= fbp_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign bus.die_sel_n              = die_sel_n_q;
    assign bus.address_latch_strobe_n = alsn_q;
    assign bus.bus_clk                = bclk_q;
    assign bus.addr                   = addr_q;
    assign bus.out_en_n               = oe_n_q;
    assign bus.write_en_n             = we_n_q;
    assign bus.flash_rst_n            = rst_n_q;
    assign bus.host_dq                = dq_q;
    assign bus.host_dq_oe             = dq_oe_q;
endmodule
`default_nettype wire

// ===== verif/fbp_asserts.sv
// Pin-level checks between the flash device end and host end.
// Assumes one shared clock; tb wires the interface signals in.
`timescale 1ns/1ps
`default_nettype none
module fbp_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus pins
    input wire logic die_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic bus_clk,
    input wire logic address_latch_strobe_n,
    input wire logic flash_rst_n,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic ready_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_dq_float: assert property (
        (die_sel_n || out_en_n) |=> !dev_dq_oe)
        else $error("dq driven while not selected");
    a_ready_float: assert property (
        (die_sel_n || out_en_n) |=> !ready_oe)
        else $error("ready driven while not selected");
    a_write_no_drive: assert property (
        !write_en_n |=> !dev_dq_oe)
        else $error("device drives dq during write");
    a_reset_quiet: assert property (
        !flash_rst_n |=> (!dev_dq_oe && !ready_oe))
        else $error("device drives pins in reset");
    a_sel_when_used: assert property (
        (!out_en_n || !write_en_n) |-> !die_sel_n)
        else $error("access without die select");
    a_host_dq_write: assert property (
        host_dq_oe |-> (!die_sel_n && out_en_n))
        else $error("host drives dq outside write");
    a_clk_idle: assert property (
        die_sel_n |-> !bus_clk)
        else $error("bus clock moves while idle");
    a_strobe_idle: assert property (
        die_sel_n |-> !address_latch_strobe_n)
        else $error("latch strobe high while idle");
    a_write_len: assert property (
        $fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n)
        else $error("write strobe low time wrong");
    a_read_drive: assert property (
        ($fell(out_en_n) && !die_sel_n) ##1 (!out_en_n && !die_sel_n)
        |-> dev_dq_oe)
        else $error("device silent in read");

    c_write: cover property ($rose(write_en_n) && !die_sel_n);
    c_read: cover property ($fell(out_en_n));
    c_sync: cover property ($rose(bus_clk));
endmodule
`default_nettype wire

// ===== verif/flash_bus_pin_interface_tb.sv
// Self-checking bench: host end drives device end over the bus.
// Assumes package, interface and both ends compile first.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_pin_interface_tb;
    logic        clk;
    logic        reset_n;
    logic        cmd_valid;
    logic        cmd_write;
    logic        cmd_sync;
    logic [25:1] cmd_addr;
    logic [15:0] cmd_wdata;
    logic        ready_pol;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic [15:0] rd;
    int          errors;
    int          checked;
    localparam logic [25:1] UP = 25'h1000000;

    fbp_bus_if bus ();
    fbp_device u_fbp_device (.clk(clk), .reset_n(reset_n), .bus(bus));
    fbp_host u_fbp_host (
        .clk       (clk),
        .reset_n   (reset_n),
        .cmd_valid (cmd_valid),
        .cmd_write (cmd_write),
        .cmd_sync  (cmd_sync),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .ready_pol (ready_pol),
        .cmd_ready (cmd_ready),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .bus       (bus)
    );
    fbp_asserts u_fbp_asserts (
        .clk         (clk),
        .reset_n     (reset_n),
        .die_sel_n   (bus.die_sel_n),
        .out_en_n    (bus.out_en_n),
        .write_en_n  (bus.write_en_n),
        .bus_clk     (bus.bus_clk),
        .address_latch_strobe_n (bus.address_latch_strobe_n),
        .flash_rst_n (bus.flash_rst_n),
        .host_dq_oe  (bus.host_dq_oe),
        .dev_dq_oe   (bus.dev_dq_oe),
        .ready_oe    (bus.ready_oe)
    );

    always #2.5 clk = ~clk;

    task automatic summarize();
        $display("Counts: checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        @(posedge clk);
        #1;
        if (n > 60) begin
            errors++;
            $display("Timeout at %0t", $time);
            summarize();
        end
    endtask

    // One request, waits for the answer
    task automatic req(input logic w, input logic s, input logic [25:1] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) begin
            n++;
            tick(n);
        end
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_sync = s;
        cmd_addr = a;
        cmd_wdata = d;
        tick(0);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            n++;
            tick(n);
        end
        rd = rsp_data;
    endtask

    task automatic wr(input logic [25:1] a, input logic [15:0] d);
        req(1'b1, 1'b0, a, d);
    endtask

    task automatic t_idle();
        chk(bus.dq, 16'hFFFF);
        chk({15'h0000, bus.die_sel_n}, 16'h0001);
        req(1'b0, 1'b0, 25'h0000010, 16'h0000);
        chk(rd, fbp_pkg::ERASED_WORD);
        $display("t_idle done");
    endtask

    task automatic t_prog();
        wr(25'h0000002, fbp_pkg::CMD_PROGRAM);
        wr(25'h0000002, 16'h1234);
        wr(25'h0000003, fbp_pkg::CMD_PROGRAM);
        wr(25'h0000003, 16'h5678);
        wr(UP | 25'h0000002, fbp_pkg::CMD_PROGRAM);
        wr(UP | 25'h0000002, 16'h9ABC);
        wr(25'h0000000, fbp_pkg::CMD_READ_ARRAY);
        req(1'b0, 1'b0, 25'h0000002, 16'h0000);
        chk(rd, 16'h1234);
        req(1'b0, 1'b0, 25'h0000003, 16'h0000);
        chk(rd, 16'h5678);
        req(1'b0, 1'b0, UP | 25'h0000002, 16'h0000);
        chk(rd, 16'h9ABC);
        $display("t_prog done");
    endtask

    task automatic t_status();
        wr(25'h0000000, fbp_pkg::CMD_READ_STATUS);
        req(1'b0, 1'b0, 25'h0000000, 16'h0000);
        chk(rd, fbp_pkg::STATUS_RESET);
        wr(25'h0000000, 16'h00AB);
        wr(25'h0000000, fbp_pkg::CMD_READ_STATUS);
        req(1'b0, 1'b0, 25'h0000000, 16'h0000);
        chk(rd, fbp_pkg::STATUS_RESET | fbp_pkg::STATUS_ERR);
        wr(25'h0000000, fbp_pkg::CMD_CLEAR_STATUS);
        wr(25'h0000000, fbp_pkg::CMD_READ_STATUS);
        req(1'b0, 1'b0, 25'h0000000, 16'h0000);
        chk(rd, fbp_pkg::STATUS_RESET);
        $display("t_status done");
    endtask

    task automatic t_sync();
        logic [15:0] cfg;
        for (int p = 0; p < 2; p++) begin
            cfg = {5'h02, p[0], 10'h000};
            wr({9'h000, cfg}, fbp_pkg::CMD_CFG_SETUP);
            wr({9'h000, cfg}, fbp_pkg::CMD_CFG_CONFIRM);
            ready_pol = p[0];
            wr(25'h0000000, fbp_pkg::CMD_READ_IDENT);
            req(1'b0, 1'b1, 25'h0000005, 16'h0000);
            chk(rd, cfg);
            wr(25'h0000000, fbp_pkg::CMD_READ_ARRAY);
            req(1'b0, 1'b1, 25'h0000003, 16'h0000);
            chk(rd, 16'h5678);
        end
        $display("t_sync done");
    endtask

    task automatic t_reset();
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        ready_pol = 1'b1;
        req(1'b0, 1'b0, 25'h0000003, 16'h0000);
        chk(rd, fbp_pkg::ERASED_WORD);
        wr(25'h0000000, fbp_pkg::CMD_READ_IDENT);
        req(1'b0, 1'b0, 25'h0000005, 16'h0000);
        chk(rd, fbp_pkg::CFG_RESET);
        $display("t_reset done");
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_sync = 1'b0;
        cmd_addr = 25'h0000000;
        cmd_wdata = 16'h0000;
        ready_pol = 1'b1;
        errors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_idle();
        t_prog();
        t_status();
        t_sync();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
